// >>> logic/rsmp_fifo.sv
// Sixteen-byte FIFO with registered head-of-queue output
`timescale 1ns/1ps
module rsmp_fifo (
    input wire logic clk,
    input wire logic rst,
    rsmp_fifo_if.mem q
);
    logic [7:0] mem [rsmp_pkg::FIFO_DEPTH];
    logic [rsmp_pkg::PTR_W-1:0] wr_ptr_reg;
    logic [rsmp_pkg::PTR_W-1:0] rd_ptr_reg;
    logic [rsmp_pkg::PTR_W-1:0] rd_ptr_inc;
    logic [rsmp_pkg::CNT_W-1:0] count_reg;
    logic [7:0] rdata_reg;
    logic do_push;
    logic do_pop;

    assign q.full = count_reg == rsmp_pkg::CNT_W'(rsmp_pkg::FIFO_DEPTH);
    assign q.empty = count_reg == '0;
    assign q.rdata = rdata_reg;
    assign do_push = q.push && !q.full;
    assign do_pop = q.pop && !q.empty;
    assign rd_ptr_inc = rsmp_pkg::PTR_W'(rd_ptr_reg + 1'b1);

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_reg] <= q.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || q.clr) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= rsmp_pkg::PTR_W'(wr_ptr_reg + 1'b1);
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_inc;
            end
            count_reg <= rsmp_pkg::CNT_W'(count_reg + do_push - do_pop);
        end
    end

    // Head kept current so a reader never waits on the memory
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (do_push && (count_reg == '0 ||
                                 (do_pop && count_reg == 5'h01))) begin
            rdata_reg <= q.wdata;
        end else begin
            rdata_reg <= mem[do_pop ? rd_ptr_inc : rd_ptr_reg];
        end
    end
endmodule

// >>> logic/rsmp_fifo_if.sv
// Handshake bundle between a port and one of its byte FIFOs
`timescale 1ns/1ps
interface rsmp_fifo_if;
    logic push;
    logic pop;
    logic clr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic full;
    logic empty;
    modport mem (input push, pop, clr, wdata, output rdata, full, empty);
    modport user (output push, pop, clr, wdata, input rdata, full, empty);
endinterface

// >>> logic/rsmp_pkg.sv
// Constants, types and helpers for the eight-port RS-485 serial adapter
package rsmp_pkg;
    localparam int N_PORTS = 8;
    localparam int PORT_BITS = 3;
    localparam int REG_BITS = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    // Host I/O map: base from switches, status word after the ports
    localparam logic [9:0] PORT_SPAN = 10'h040;
    localparam logic [9:0] STAT_OFS = 10'h040;
    // Register index within one port
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_IER = 3'h1;
    localparam logic [2:0] REG_IIR = 3'h2;
    localparam logic [2:0] REG_LCR = 3'h3;
    localparam logic [2:0] REG_MCR = 3'h4;
    localparam logic [2:0] REG_LSR = 3'h5;
    localparam logic [2:0] REG_MSR = 3'h6;
    localparam logic [2:0] REG_SCR = 3'h7;
    // Field positions
    localparam int IER_RDA = 0;
    localparam int IER_THRE = 1;
    localparam int FCR_EN = 0;
    localparam int FCR_RXCLR = 1;
    localparam int FCR_TXCLR = 2;
    localparam int LCR_STB = 2;
    localparam int LCR_DLAB = 7;
    localparam int MCR_OUT2 = 3;
    // Interrupt identification codes
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_THRE = 4'h2;
    localparam logic [3:0] IIR_RDA = 4'h4;
    // Reset values
    localparam logic [7:0] LCR_RST = 8'h03;
    localparam logic [15:0] DIV_RST = 16'h000c;
    // Timing: 16x oversampling of a crystal-rate tick
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_PT = 4'h7;
    localparam int OVS_LOG2 = 4;
    localparam logic [27:0] CLK_HZ = 28'hee6b280;  // 250 MHz
    localparam logic [27:0] XTAL_HZ = 28'h01c2000; // 1.8432 MHz

    typedef enum logic [1:0] {DIR_IDLE, DIR_SEND, DIR_HOLD} rsmp_dir_e;

    function automatic logic [3:0] data_bits(input logic [7:0] lcr);
        data_bits = 4'(4'h5 + {2'h0, lcr[1:0]});
    endfunction

    function automatic logic [3:0] char_bits(input logic [7:0] lcr);
        char_bits = 4'(4'h1 + data_bits(lcr) + (lcr[LCR_STB] ? 4'h2 : 4'h1));
    endfunction
endpackage

// >>> logic/rsmp_top.sv
// Eight-port RS-485 serial adapter with automatic driver direction
//
// What this block does
// - Driver turns on when transmit data waits
// - Driver held one character after last transfer
// - Receiver gated off while port transmits
// - Hold time follows the programmed bit rate
// - Half-duplex pair, never send and receive together
// - Sixteen-byte FIFOs, classic serial register set
// - Divisor gives rates from 50 to 115200
// - Readable status word shows ports wanting service
// - All ports may share one interrupt line
// - Base address decoded from switch setting
// - Three low address lines pick the register
`timescale 1ns/1ps
module rsmp_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [9:0] IO_ADDR,
    input wire logic IOR_N,
    input wire logic IOW_N,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    input wire logic [6:0] BASE_SW,
    output logic [7:0] TXD,
    input wire logic [7:0] RXD,
    output logic [7:0] DE,
    output logic [7:0] RE_N,
    output logic [7:0] IRQ,
    output logic IRQ_ALL
);
    localparam int N = rsmp_pkg::N_PORTS;

    logic ior_d_reg;
    logic iow_d_reg;
    logic rd_pulse;
    logic wr_pulse;
    logic [9:0] base_addr;
    logic [9:0] addr_off;
    logic port_hit;
    logic stat_hit;
    logic [rsmp_pkg::PORT_BITS-1:0] port_idx;
    logic [rsmp_pkg::REG_BITS-1:0] reg_idx;
    logic [7:0] rd_val [N];
    logic [N-1:0] irq_pend;
    logic [N-1:0] irq_gated;
    logic [7:0] data_out_reg;
    logic data_oe_reg;
    logic irq_all_reg;
    logic [27:0] xtal_acc_reg;
    logic [28:0] xtal_sum;
    logic xtal_tick;

    // Crystal-rate enable by phase accumulation from the system clock
    assign xtal_sum = 29'(xtal_acc_reg) + 29'(rsmp_pkg::XTAL_HZ);
    assign xtal_tick = xtal_sum >= 29'(rsmp_pkg::CLK_HZ);

    always_ff @(posedge CLK) begin
        if (RST) begin
            xtal_acc_reg <= 28'h0000000;
        end else if (xtal_tick) begin
            xtal_acc_reg <= 28'(xtal_sum - 29'(rsmp_pkg::CLK_HZ));
        end else begin
            xtal_acc_reg <= 28'(xtal_sum);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ior_d_reg <= 1'b1;
            iow_d_reg <= 1'b1;
        end else begin
            ior_d_reg <= IOR_N;
            iow_d_reg <= IOW_N;
        end
    end

    // A strobe acts once, on its falling edge
    assign rd_pulse = ior_d_reg && !IOR_N;
    assign wr_pulse = iow_d_reg && !IOW_N;

    assign base_addr = {BASE_SW, 3'h0};
    assign addr_off = 10'(IO_ADDR - base_addr);
    assign port_idx = addr_off[rsmp_pkg::REG_BITS +: rsmp_pkg::PORT_BITS];
    assign reg_idx = addr_off[rsmp_pkg::REG_BITS-1:0];

    always_comb begin
        port_hit = 1'b0;
        stat_hit = 1'b0;
        if (IO_ADDR < base_addr) begin
            port_hit = 1'b0;
        end else if (addr_off < rsmp_pkg::PORT_SPAN) begin
            port_hit = 1'b1;
        end else if (addr_off == rsmp_pkg::STAT_OFS) begin
            stat_hit = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            data_out_reg <= 8'h00;
        end else if (rd_pulse && stat_hit) begin
            data_out_reg <= irq_pend;
        end else if (rd_pulse && port_hit) begin
            data_out_reg <= rd_val[port_idx];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || IOR_N) begin
            data_oe_reg <= 1'b0;
        end else if (rd_pulse && (port_hit || stat_hit)) begin
            data_oe_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_all_reg <= 1'b0;
        end else begin
            irq_all_reg <= |irq_gated;
        end
    end

    assign DATA_OUT = data_out_reg;
    assign DATA_OE = data_oe_reg;
    assign IRQ_ALL = irq_all_reg;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_port
            rsmp_fifo_if tx_q ();
            rsmp_fifo_if rx_q ();
            logic sel;
            logic wr;
            logic rd;
            logic dlab;
            logic [7:0] ier_reg;
            logic [7:0] lcr_reg;
            logic [7:0] mcr_reg;
            logic [7:0] scr_reg;
            logic [15:0] div_reg;
            logic fcr_en_reg;
            logic oe_reg;
            logic [15:0] div_cnt_reg;
            logic tick16;
            logic [3:0] dbits;
            rsmp_pkg::rsmp_dir_e dir_reg;
            logic [7:0] hold_reg;
            logic [11:0] tx_sh_reg;
            logic [3:0] tx_bits_reg;
            logic [3:0] tx_sub_reg;
            logic tx_busy;
            logic tx_load;
            logic rx_act_reg;
            logic [3:0] rx_sub_reg;
            logic [3:0] rx_idx_reg;
            logic [7:0] rx_sh_reg;
            logic rxd_g;
            logic rx_done;
            logic txd_reg;
            logic de_reg;
            logic irq_reg;
            logic [3:0] iid;

            rsmp_fifo u_txf (.clk(CLK), .rst(RST), .q(tx_q.mem));
            rsmp_fifo u_rxf (.clk(CLK), .rst(RST), .q(rx_q.mem));

            assign sel = port_hit && port_idx == 3'(g);
            assign wr = wr_pulse && sel;
            assign rd = rd_pulse && sel;
            assign dlab = lcr_reg[rsmp_pkg::LCR_DLAB];
            assign dbits = rsmp_pkg::data_bits(lcr_reg);

            always_ff @(posedge CLK) begin
                if (RST) begin
                    ier_reg <= 8'h00;
                    lcr_reg <= rsmp_pkg::LCR_RST;
                    mcr_reg <= 8'h00;
                    scr_reg <= 8'h00;
                    div_reg <= rsmp_pkg::DIV_RST;
                    fcr_en_reg <= 1'b0;
                end else if (wr) begin
                    case (reg_idx)
                        rsmp_pkg::REG_DATA: begin
                            if (dlab) begin
                                div_reg[7:0] <= DATA_IN;
                            end
                        end
                        rsmp_pkg::REG_IER: begin
                            if (dlab) begin
                                div_reg[15:8] <= DATA_IN;
                            end else begin
                                ier_reg <= DATA_IN;
                            end
                        end
                        rsmp_pkg::REG_IIR: begin
                            fcr_en_reg <= DATA_IN[rsmp_pkg::FCR_EN];
                        end
                        rsmp_pkg::REG_LCR: lcr_reg <= DATA_IN;
                        rsmp_pkg::REG_MCR: mcr_reg <= DATA_IN;
                        rsmp_pkg::REG_SCR: scr_reg <= DATA_IN;
                        default: begin
                        end
                    endcase
                end
            end

            assign tx_q.push = wr && reg_idx == rsmp_pkg::REG_DATA && !dlab;
            assign tx_q.wdata = DATA_IN;
            assign tx_q.clr = wr && reg_idx == rsmp_pkg::REG_IIR &&
                              DATA_IN[rsmp_pkg::FCR_TXCLR];
            assign rx_q.pop = rd && reg_idx == rsmp_pkg::REG_DATA && !dlab;
            assign rx_q.clr = wr && reg_idx == rsmp_pkg::REG_IIR &&
                              DATA_IN[rsmp_pkg::FCR_RXCLR];

            // Divisor counts crystal ticks; zero behaves as the largest
            assign tick16 = xtal_tick &&
                            div_cnt_reg >= 16'(div_reg - 16'h0001);

            always_ff @(posedge CLK) begin
                if (RST) begin
                    div_cnt_reg <= 16'h0000;
                end else if (tick16) begin
                    div_cnt_reg <= 16'h0000;
                end else if (xtal_tick) begin
                    div_cnt_reg <= 16'(div_cnt_reg + 16'h0001);
                end
            end

            // Direction control; hold length tracks frame format and rate
            always_ff @(posedge CLK) begin
                if (RST) begin
                    dir_reg <= rsmp_pkg::DIR_IDLE;
                    hold_reg <= 8'h00;
                end else begin
                    case (dir_reg)
                        rsmp_pkg::DIR_IDLE: begin
                            if (!tx_q.empty) begin
                                dir_reg <= rsmp_pkg::DIR_SEND;
                            end
                        end
                        rsmp_pkg::DIR_SEND: begin
                            if (tx_q.empty && !tx_busy) begin
                                dir_reg <= rsmp_pkg::DIR_HOLD;
                                hold_reg <= 8'(rsmp_pkg::char_bits(lcr_reg))
                                            << rsmp_pkg::OVS_LOG2;
                            end
                        end
                        rsmp_pkg::DIR_HOLD: begin
                            if (!tx_q.empty) begin
                                dir_reg <= rsmp_pkg::DIR_SEND;
                            end else if (tick16) begin
                                if (hold_reg <= 8'h01) begin
                                    dir_reg <= rsmp_pkg::DIR_IDLE;
                                end else begin
                                    hold_reg <= 8'(hold_reg - 8'h01);
                                end
                            end
                        end
                        default: dir_reg <= rsmp_pkg::DIR_IDLE;
                    endcase
                end
            end

            // Frame starts only once the driver is already on
            assign tx_busy = tx_bits_reg != 4'h0;
            assign tx_load = !tx_q.empty && !tx_busy &&
                             dir_reg != rsmp_pkg::DIR_IDLE;
            assign tx_q.pop = tx_load;

            always_ff @(posedge CLK) begin
                if (RST) begin
                    tx_sh_reg <= 12'hfff;
                    tx_bits_reg <= 4'h0;
                    tx_sub_reg <= 4'h0;
                end else if (tx_load) begin
                    // Unused upper data bits become extra stop level
                    tx_sh_reg <= {3'h7, tx_q.rdata | 8'(8'hff << dbits),
                                  1'b0};
                    tx_bits_reg <= rsmp_pkg::char_bits(lcr_reg);
                    tx_sub_reg <= 4'h0;
                end else if (tx_busy && tick16) begin
                    tx_sub_reg <= 4'(tx_sub_reg + 4'h1);
                    if (tx_sub_reg == rsmp_pkg::OVS_LAST) begin
                        tx_sh_reg <= {1'b1, tx_sh_reg[11:1]};
                        tx_bits_reg <= 4'(tx_bits_reg - 4'h1);
                    end
                end
            end

            // Own echo never reaches the receiver
            assign rxd_g = de_reg ? 1'b1 : RXD[g];
            assign rx_done = rx_act_reg && tick16 &&
                             rx_sub_reg == rsmp_pkg::SAMPLE_PT &&
                             rx_idx_reg > dbits;
            assign rx_q.push = rx_done && rxd_g;
            assign rx_q.wdata = 8'(rx_sh_reg >> (4'h8 - dbits));

            always_ff @(posedge CLK) begin
                if (RST || de_reg) begin
                    rx_act_reg <= 1'b0;
                    rx_sub_reg <= 4'h0;
                    rx_idx_reg <= 4'h0;
                    rx_sh_reg <= 8'h00;
                end else if (tick16) begin
                    if (!rx_act_reg) begin
                        rx_act_reg <= !rxd_g;
                        rx_sub_reg <= 4'h0;
                        rx_idx_reg <= 4'h0;
                    end else begin
                        rx_sub_reg <= 4'(rx_sub_reg + 4'h1);
                        if (rx_sub_reg == rsmp_pkg::SAMPLE_PT) begin
                            rx_idx_reg <= 4'(rx_idx_reg + 4'h1);
                            if (rx_idx_reg == 4'h0) begin
                                rx_act_reg <= !rxd_g;
                            end else if (rx_idx_reg <= dbits) begin
                                rx_sh_reg <= {rxd_g, rx_sh_reg[7:1]};
                            end else begin
                                rx_act_reg <= 1'b0;
                            end
                        end
                    end
                end
            end

            // Overrun: a new arrival beats a status read in the same cycle
            always_ff @(posedge CLK) begin
                if (RST) begin
                    oe_reg <= 1'b0;
                end else if (rx_q.push && rx_q.full) begin
                    oe_reg <= 1'b1;
                end else if (rd && reg_idx == rsmp_pkg::REG_LSR) begin
                    oe_reg <= 1'b0;
                end
            end

            assign iid = (ier_reg[rsmp_pkg::IER_RDA] && !rx_q.empty) ?
                         rsmp_pkg::IIR_RDA :
                         (ier_reg[rsmp_pkg::IER_THRE] && tx_q.empty) ?
                         rsmp_pkg::IIR_THRE : rsmp_pkg::IIR_NONE;
            assign irq_pend[g] = iid != rsmp_pkg::IIR_NONE;
            assign irq_gated[g] = irq_pend[g] &&
                                  mcr_reg[rsmp_pkg::MCR_OUT2];

            always_comb begin
                case (reg_idx)
                    rsmp_pkg::REG_DATA:
                        rd_val[g] = dlab ? div_reg[7:0] : rx_q.rdata;
                    rsmp_pkg::REG_IER:
                        rd_val[g] = dlab ? div_reg[15:8] : ier_reg;
                    rsmp_pkg::REG_IIR:
                        rd_val[g] = {{2{fcr_en_reg}}, 2'h0, iid};
                    rsmp_pkg::REG_LCR: rd_val[g] = lcr_reg;
                    rsmp_pkg::REG_MCR: rd_val[g] = mcr_reg;
                    rsmp_pkg::REG_LSR:
                        rd_val[g] = {1'b0, tx_q.empty && !tx_busy,
                                     tx_q.empty, 3'h0, oe_reg,
                                     !rx_q.empty};
                    rsmp_pkg::REG_SCR: rd_val[g] = scr_reg;
                    default: rd_val[g] = 8'h00;
                endcase
            end

            always_ff @(posedge CLK) begin
                if (RST) begin
                    txd_reg <= 1'b1;
                    de_reg <= 1'b0;
                    irq_reg <= 1'b0;
                end else begin
                    txd_reg <= tx_busy ? tx_sh_reg[0] : 1'b1;
                    de_reg <= dir_reg != rsmp_pkg::DIR_IDLE;
                    irq_reg <= irq_gated[g];
                end
            end

            assign TXD[g] = txd_reg;
            assign DE[g] = de_reg;
            assign RE_N[g] = de_reg;
            assign IRQ[g] = irq_reg;
        end
    endgenerate
endmodule

// >>> testbench/rs485_auto_direction_multiport_serial_tb_top.sv
// Host and line stimulus with self-checks for the RS-485 adapter
`timescale 1ns/1ps
module rs485_auto_direction_multiport_serial_tb_top;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [9:0] IO_ADDR = 10'h000;
    logic IOR_N = 1'b1;
    logic IOW_N = 1'b1;
    logic [7:0] DATA_IN = 8'h00;
    logic [6:0] BASE_SW = 7'h20;
    logic [7:0] DATA_OUT, TXD, DE, RE_N, IRQ;
    logic DATA_OE, IRQ_ALL, node_line;
    logic node_go = 1'b0;
    logic [7:0] node_byte = 8'h00;
    logic [9:0] base;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h00000004;
    assign base = {BASE_SW, 3'h0};
    always #2 CLK = ~CLK;
    rsmp_top dut_u (.CLK(CLK), .RST(RST), .IO_ADDR(IO_ADDR), .IOR_N(IOR_N),
        .IOW_N(IOW_N), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
        .DATA_OE(DATA_OE), .BASE_SW(BASE_SW), .TXD(TXD),
        .RXD({6'h3f, node_line, 1'b1}), .DE(DE), .RE_N(RE_N), .IRQ(IRQ),
        .IRQ_ALL(IRQ_ALL));
    rsmp_node_model node_u (.clk(CLK), .send(node_go), .byte_v(node_byte),
        .line(node_line));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            fail_count++;
            complete_run();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        xs = v ^ (v << 5);
    endfunction
    // Clock cycles for a number of bit times at 16 crystal ticks a bit
    function automatic int exp_cyc(input int bits);
        exp_cyc = int'(longint'(bits) * 64'hee6b2800 / 64'h1c2000);
    endfunction
    function automatic int char_len(input logic [7:0] lcr);
        char_len = 1 + 5 + int'(lcr[1:0]) + (lcr[2] ? 2 : 1);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge CLK);
        IO_ADDR <= a;
        DATA_IN <= d;
        IOW_N <= 1'b0;
        repeat (2) @(posedge CLK);
        IOW_N <= 1'b1;
        @(posedge CLK);
    endtask
    task automatic io_rd(input logic [9:0] a, output logic [7:0] d,
                         output logic oe);
        @(posedge CLK);
        IO_ADDR <= a;
        IOR_N <= 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        d = DATA_OUT;
        oe = DATA_OE;
        @(posedge CLK);
        IOR_N <= 1'b1;
        @(posedge CLK);
    endtask
    // Fastest divisor keeps each frame near 22k cycles
    task automatic set_fast(input logic [9:0] pb);
        io_wr(pb + 10'h3, 8'h83);
        io_wr(pb, 8'h01);
        io_wr(pb + 10'h1, 8'h00);
        io_wr(pb + 10'h3, 8'h03);
    endtask
    initial begin
        logic [7:0] d, b;
        logic oe;
        int t0;
        seed = xs(seed);
        BASE_SW <= 7'h20 + {3'h0, seed[3:0]};
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        repeat (2) @(posedge CLK);
        // Look after the edge so registered outputs have settled
        #1;
        check(DE, 8'h00, "driver on after reset");
        check(TXD, 8'hff, "line not idle after reset");
        io_rd(base + 10'h048, d, oe);
        check({7'h0, oe}, 8'h00, "unmapped read drove bus");
        io_rd(base + 10'h040, d, oe);
        check(d, 8'h00, "status word not clear");
        seed = xs(seed);
        io_wr(base + 10'h17, seed[7:0]);
        io_rd(base + 10'h17, d, oe);
        check(d, seed[7:0], "scratch readback");
        io_rd(base + 10'h1f, d, oe);
        check(d, 8'h00, "scratch of next port disturbed");
        seed = xs(seed);
        b = seed[7:0];
        set_fast(base);
        io_wr(base, b);
        for (int i = 0; i < 4 && DE[0] !== 1'b1; i++) @(posedge CLK);
        check({7'h0, DE[0]}, 8'h01, "driver not on with data");
        check({7'h0, RE_N[0]}, 8'h01, "receiver on while sending");
        for (int i = 0; i < 300 && TXD[0] !== 1'b0; i++) @(posedge CLK);
        t0 = cycles;
        repeat (1085) @(posedge CLK);
        check({7'h0, TXD[0]}, 8'h00, "start bit");
        for (int i = 0; i < 8; i++) begin
            repeat (2170) @(posedge CLK);
            d[i] = TXD[0];
        end
        check(d, b, "sent byte");
        repeat (2170) @(posedge CLK);
        check({7'h0, TXD[0]}, 8'h01, "stop bit");
        for (int i = 0; i < 50000 && DE[0] !== 1'b0; i++) @(posedge CLK);
        t0 = cycles - t0 - exp_cyc(2 * char_len(8'h03));
        check({7'h0, t0 <= 300 && t0 >= -300}, 8'h01, "hold time");
        set_fast(base + 10'h8);
        io_wr(base + 10'h9, 8'h01);
        io_wr(base + 10'hc, 8'h08);
        // Port 2 sends a short 5N1 frame while port 1 receives
        set_fast(base + 10'h10);
        io_wr(base + 10'h13, 8'h00);
        io_wr(base + 10'h10, seed[23:16]);
        t0 = cycles;
        seed = xs(seed);
        node_byte <= seed[7:0];
        node_go <= 1'b1;
        @(posedge CLK);
        node_go <= 1'b0;
        for (int i = 0; i < 30000 && IRQ[1] !== 1'b1; i++) @(posedge CLK);
        check(IRQ, 8'h02, "port interrupt");
        check({7'h0, IRQ_ALL}, 8'h01, "common interrupt");
        io_rd(base + 10'h040, d, oe);
        check(d, 8'h02, "status word request");
        io_rd(base + 10'hd, d, oe);
        check({7'h0, d[0]}, 8'h01, "data ready");
        io_rd(base + 10'h8, d, oe);
        check(d, node_byte, "received byte");
        io_rd(base + 10'h040, d, oe);
        check(d, 8'h00, "status word after service");
        check(IRQ, 8'h00, "interrupt after service");
        for (int i = 0; i < 30000 && DE[2] !== 1'b0; i++) @(posedge CLK);
        t0 = cycles - t0 - exp_cyc(2 * char_len(8'h00));
        check({7'h0, t0 <= 300 && t0 >= -300}, 8'h01, "short hold");
        complete_run();
    end
endmodule

// >>> testbench/rsmp_node_model.sv
// Remote RS-485 node that sends one framed byte on request
`timescale 1ns/1ps
module rsmp_node_model #(parameter int BIT_CYC = 2170) (
    input wire logic clk,
    input wire logic send,
    input wire logic [7:0] byte_v,
    output logic line
);
    initial begin
        line = 1'b1;
    end
    // Start, 8 data LSB first, stop; bias keeps line high between frames
    always begin
        @(posedge clk);
        if (send) begin
            line <= 1'b0;
            for (int i = 0; i < 10; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                line <= (i < 8) ? byte_v[i] : 1'b1;
            end
        end
    end
endmodule

// >>> testbench/rsmp_top_properties.sv
// Port-level timing checks for the RS-485 serial adapter
`timescale 1ns/1ps
module rsmp_top_properties (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [9:0] IO_ADDR,
    input wire logic IOR_N,
    input wire logic DATA_OE,
    input wire logic [6:0] BASE_SW,
    input wire logic [7:0] TXD,
    input wire logic [7:0] DE,
    input wire logic [7:0] RE_N,
    input wire logic [7:0] IRQ,
    input wire logic IRQ_ALL
);
    logic [9:0] ofs;
    logic hit;
    logic [15:0] hold_reg;
    assign ofs = IO_ADDR - {BASE_SW, 3'h0};
    assign hit = (IO_ADDR >= {BASE_SW, 3'h0}) && (ofs <= 10'h040);
    // Idle-high cycles with the driver on; shortest legal char is 5N1
    always_ff @(posedge CLK) begin
        if (RST || !(DE[0] && TXD[0]))
            hold_reg <= 16'h0000;
        else if (hold_reg != 16'hffff)
            hold_reg <= hold_reg + 16'h0001;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    re_mirror_a: assert property (RE_N == DE)
        else $error("receiver enable does not follow driver");
    irq_share_a: assert property (IRQ_ALL == (|IRQ))
        else $error("common interrupt differs from port lines");
    txd_idle_a: assert property ((TXD | DE) == 8'hff)
        else $error("serial out active with driver off");
    start_bit_a: assert property ($rose(DE[0]) |-> ##[0:140] !TXD[0])
        else $error("no start bit after driver on");
    hold_min_a: assert property ($fell(DE[0]) |-> hold_reg >= 16'h3a98)
        else $error("driver released before one character");
    read_oe_a: assert property (($fell(IOR_N) && hit && !$past(RST))
        |-> ##[1:2] DATA_OE)
        else $error("decoded read did not drive bus");
    miss_oe_a: assert property (($fell(IOR_N) && !hit)
        |=> !DATA_OE ##1 !DATA_OE)
        else $error("unmatched read drove bus");
    oe_release_a: assert property ($rose(IOR_N) |-> ##[1:2] !DATA_OE)
        else $error("bus still driven after read");
endmodule
bind rsmp_top rsmp_top_properties chk_u (.CLK(CLK), .RST(RST),
    .IO_ADDR(IO_ADDR), .IOR_N(IOR_N), .DATA_OE(DATA_OE), .BASE_SW(BASE_SW),
    .TXD(TXD), .DE(DE), .RE_N(RE_N), .IRQ(IRQ), .IRQ_ALL(IRQ_ALL));
